// ===== core/tdcop_pkg.sv
// Shared constants and carriers for the readout opcode interpreter.
package tdcop_pkg;

  // ---------------------------------------------------------------
  // Bus register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_CFG = 8'h08;

  // ---------------------------------------------------------------
  // Opcode high bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_RD_RES = 8'h26;
  localparam logic [7:0] OP_SET_DEAD = 8'h28;
  localparam logic [7:0] OP_RD_DEAD = 8'h29;
  localparam logic [7:0] OP_HT_ON = 8'h30;
  localparam logic [7:0] OP_HT_OFF = 8'h31;
  localparam logic [7:0] OP_RD_HT = 8'h32;
  localparam logic [7:0] OP_SET_LIM = 8'h33;
  localparam logic [7:0] OP_RD_LIM = 8'h34;
  localparam logic [7:0] OP_MARK_ON = 8'h35;
  localparam logic [7:0] OP_MARK_OFF = 8'h36;
  localparam logic [7:0] OP_BYP_ON = 8'h37;
  localparam logic [7:0] OP_BYP_OFF = 8'h38;
  localparam logic [7:0] OP_SET_ERRT = 8'h39;
  localparam logic [7:0] OP_RD_ERRT = 8'h3a;
  localparam logic [7:0] OP_SET_BUF = 8'h3b;
  localparam logic [7:0] OP_RD_BUF = 8'h3c;
  localparam logic [7:0] OP_CH_ON = 8'h40;
  localparam logic [7:0] OP_CH_OFF = 8'h41;
  localparam logic [7:0] OP_ALL_ON = 8'h42;
  localparam logic [7:0] OP_ALL_OFF = 8'h43;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int STAT_WAIT_DATA = 0;
  localparam int STAT_RESP_RDY = 1;
  localparam int STAT_PAIR = 2;
  localparam logic [1:0] EDGE_PAIR = 2'h0;
  localparam logic [3:0] LIM_NONE = 4'h9;
  localparam logic [15:0] SIZE_ERR_WORD = 16'h1000;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_EDGE = 2'h3;
  localparam logic [1:0] RST_LT_RES = 2'h3;
  localparam logic [2:0] RST_PAIR_LEAD = 3'h0;
  localparam logic [3:0] RST_PAIR_WIDTH = 4'h0;
  localparam logic [1:0] RST_DEAD = 2'h0;
  localparam logic [3:0] RST_LIM = 4'h9;
  localparam logic [2:0] RST_BUF = 3'h7;
  localparam logic [10:0] RST_ERRT = 11'h7ff;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_DATA,
    ST_WAIT_READ
  } tdcop_state_e;

  typedef enum logic [1:0] {
    EV_IDLE,
    EV_ERR,
    EV_TRL
  } tdcop_evt_e;

  // Settings that the interpreter hands to the acquisition logic.
  typedef struct packed {
    logic hdr_trl_en;
    logic err_mark_en;
    logic bypass_en;
    logic [1:0] dead_time;
    logic [3:0] hit_limit;
    logic [10:0] err_type_en;
    logic [2:0] buf_size;
  } tdcop_cfg_s;

endpackage

// ===== core/tdcop_interp.sv
// Opcode interpreter with Wishbone command port and event size guard.
`timescale 1ns/1ps
module tdcop_interp #(
  parameter int NCH = 32
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Settings toward the acquisition logic
  output tdcop_pkg::tdcop_cfg_s cfg_o,
  output logic [NCH-1:0] chan_en_o,
  output logic [1:0] edge_mode_o,
  output logic low_res_o,
  // Event size guard
  input wire logic hit_i,
  input wire logic evt_end_i,
  output logic hit_keep_o,
  output logic size_err_o,
  output logic [15:0] size_err_word_o,
  output logic trailer_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    tdcop_pkg::tdcop_state_e st;
    logic [7:0] pend_op;
    logic [15:0] resp;
    logic ack;
    logic [31:0] dat;
    tdcop_pkg::tdcop_cfg_s cfg;
    logic [NCH-1:0] chan_en;
    logic [1:0] edge_mode;
    logic low_res;
    logic [1:0] lt_res;
    logic [2:0] pair_lead;
    logic [3:0] pair_width;
    logic [8:0] hit_cnt;
    logic over;
    tdcop_pkg::tdcop_evt_e ev;
    logic keep;
    logic serr;
    logic trl;
  } tdcop_regs_s;

  tdcop_regs_s q, d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Largest hit count allowed by a limit code; codes above 8 act as no limit.
  function automatic logic [8:0] tdcop_limit(input logic [3:0] code);
    logic [8:0] r;
    r = 9'h000;
    if (code != 4'h0 && code <= 4'h8) begin
      r = 9'(9'h001 << (code - 4'h1));
    end
    return r;
  endfunction

  function automatic logic tdcop_unlimited(input logic [3:0] code);
    return code > 4'h8;
  endfunction

  function automatic logic tdcop_pair(input logic [1:0] edge_mode, input logic low_res);
    return (edge_mode == tdcop_pkg::EDGE_PAIR) && low_res;
  endfunction

  // Response word of a read opcode.
  function automatic logic [15:0] tdcop_answer(input tdcop_regs_s s, input logic [7:0] op);
    logic [15:0] w;
    w = 16'h0000;
    if (op == tdcop_pkg::OP_RD_RES) begin
      if (tdcop_pair(s.edge_mode, s.low_res)) begin
        w = {4'h0, s.pair_width, 5'h00, s.pair_lead};
      end else begin
        w = {14'h0000, s.lt_res};
      end
    end else if (op == tdcop_pkg::OP_RD_DEAD) begin
      w = {14'h0000, s.cfg.dead_time};
    end else if (op == tdcop_pkg::OP_RD_HT) begin
      w = {15'h0000, s.cfg.hdr_trl_en};
    end else if (op == tdcop_pkg::OP_RD_LIM) begin
      w = {12'h000, s.cfg.hit_limit};
    end else if (op == tdcop_pkg::OP_RD_ERRT) begin
      w = {5'h00, s.cfg.err_type_en};
    end else if (op == tdcop_pkg::OP_RD_BUF) begin
      w = {13'h0000, s.cfg.buf_size};
    end
    return w;
  endfunction

  function automatic logic tdcop_is_read(input logic [7:0] op);
    return op == tdcop_pkg::OP_RD_RES || op == tdcop_pkg::OP_RD_DEAD || op == tdcop_pkg::OP_RD_HT ||
           op == tdcop_pkg::OP_RD_LIM || op == tdcop_pkg::OP_RD_ERRT || op == tdcop_pkg::OP_RD_BUF;
  endfunction

  function automatic logic tdcop_takes_data(input logic [7:0] op);
    return op == tdcop_pkg::OP_SET_DEAD || op == tdcop_pkg::OP_SET_LIM ||
           op == tdcop_pkg::OP_SET_ERRT || op == tdcop_pkg::OP_SET_BUF;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic take;
  logic [15:0] word;
  logic [7:0] op;
  logic [7:0] idx;

  always_comb begin
    d = q;
    take = wb_cyc_i && wb_stb_i && !q.ack;
    word = wb_dat_i[15:0];
    op = word[15:8];
    idx = word[7:0];
    d.ack = take;
    d.dat = 32'h0000_0000;
    d.keep = 1'b0;
    d.serr = 1'b0;
    d.trl = 1'b0;

    // Register bus access, acted on in the cycle that raises ack.
    if (take) begin
      if (wb_adr_i == tdcop_pkg::ADR_CMD) begin
        if (wb_we_i && wb_sel_i[1:0] == 2'h3) begin
          case (q.st)
            tdcop_pkg::ST_IDLE: begin
              if (tdcop_takes_data(op)) begin
                d.pend_op = op;
                d.st = tdcop_pkg::ST_WAIT_DATA;
              end else if (tdcop_is_read(op)) begin
                d.resp = tdcop_answer(q, op);
                d.st = tdcop_pkg::ST_WAIT_READ;
              end else if (op == tdcop_pkg::OP_HT_ON) begin
                d.cfg.hdr_trl_en = 1'b1;
              end else if (op == tdcop_pkg::OP_HT_OFF) begin
                d.cfg.hdr_trl_en = 1'b0;
              end else if (op == tdcop_pkg::OP_MARK_ON) begin
                d.cfg.err_mark_en = 1'b1;
              end else if (op == tdcop_pkg::OP_MARK_OFF) begin
                d.cfg.err_mark_en = 1'b0;
              end else if (op == tdcop_pkg::OP_BYP_ON) begin
                d.cfg.bypass_en = 1'b1;
              end else if (op == tdcop_pkg::OP_BYP_OFF) begin
                d.cfg.bypass_en = 1'b0;
              end else if (op == tdcop_pkg::OP_CH_ON) begin
                // Out of range indices are dropped; acquisition is never paused here.
                if (idx < 8'(NCH)) begin
                  d.chan_en[idx[$clog2(NCH)-1:0]] = 1'b1;
                end
              end else if (op == tdcop_pkg::OP_CH_OFF) begin
                if (idx < 8'(NCH)) begin
                  d.chan_en[idx[$clog2(NCH)-1:0]] = 1'b0;
                end
              end else if (op == tdcop_pkg::OP_ALL_ON) begin
                d.chan_en = '1;
              end else if (op == tdcop_pkg::OP_ALL_OFF) begin
                d.chan_en = '0;
              end
            end
            tdcop_pkg::ST_WAIT_DATA: begin
              // The data word comes through the opcode location itself.
              if (q.pend_op == tdcop_pkg::OP_SET_DEAD) begin
                d.cfg.dead_time = word[1:0];
              end else if (q.pend_op == tdcop_pkg::OP_SET_LIM) begin
                d.cfg.hit_limit = word[3:0];
              end else if (q.pend_op == tdcop_pkg::OP_SET_ERRT) begin
                d.cfg.err_type_en = word[10:0];
              end else begin
                d.cfg.buf_size = word[2:0];
              end
              d.st = tdcop_pkg::ST_IDLE;
            end
            default: begin
              // A write while a response is pending is ignored.
              d.st = q.st;
            end
          endcase
        end else if (!wb_we_i) begin
          if (q.st == tdcop_pkg::ST_WAIT_READ) begin
            d.dat = {16'h0000, q.resp};
            d.st = tdcop_pkg::ST_IDLE;
          end
        end
      end else if (wb_adr_i == tdcop_pkg::ADR_STAT) begin
        d.dat[tdcop_pkg::STAT_WAIT_DATA] = q.st == tdcop_pkg::ST_WAIT_DATA;
        d.dat[tdcop_pkg::STAT_RESP_RDY] = q.st == tdcop_pkg::ST_WAIT_READ;
        d.dat[tdcop_pkg::STAT_PAIR] = tdcop_pair(q.edge_mode, q.low_res);
      end else if (wb_adr_i == tdcop_pkg::ADR_CFG) begin
        if (wb_we_i) begin
          if (wb_sel_i[0]) begin
            d.edge_mode = wb_dat_i[1:0];
            d.low_res = wb_dat_i[2];
            d.lt_res = wb_dat_i[5:4];
          end
          if (wb_sel_i[1]) begin
            d.pair_lead = wb_dat_i[10:8];
            d.pair_width = wb_dat_i[15:12];
          end
        end else begin
          d.dat = {16'h0000, q.pair_width, 1'b0, q.pair_lead, 2'h0, q.lt_res, 1'b0, q.low_res, q.edge_mode};
        end
      end
    end

    // Event size guard: hits past the limit are dropped and flagged.
    if (hit_i) begin
      if (tdcop_unlimited(q.cfg.hit_limit) || q.hit_cnt < tdcop_limit(q.cfg.hit_limit)) begin
        d.keep = 1'b1;
        if (q.hit_cnt != 9'h1ff) begin
          d.hit_cnt = q.hit_cnt + 9'h001;
        end
      end else begin
        d.over = 1'b1;
      end
    end
    case (q.ev)
      tdcop_pkg::EV_ERR: begin
        d.serr = 1'b1;
        if (q.cfg.hdr_trl_en) begin
          d.ev = tdcop_pkg::EV_TRL;
        end else begin
          d.ev = tdcop_pkg::EV_IDLE;
        end
      end
      tdcop_pkg::EV_TRL: begin
        d.trl = 1'b1;
        d.ev = tdcop_pkg::EV_IDLE;
      end
      default: begin
        d.ev = tdcop_pkg::EV_IDLE;
      end
    endcase
    if (evt_end_i) begin
      // The error word goes out first so it lands ahead of the trailer.
      if (d.over) begin
        d.ev = tdcop_pkg::EV_ERR;
      end else if (q.cfg.hdr_trl_en) begin
        d.ev = tdcop_pkg::EV_TRL;
      end
      d.hit_cnt = 9'h000;
      d.over = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.st <= tdcop_pkg::ST_IDLE;
      q.pend_op <= 8'h00;
      q.resp <= 16'h0000;
      q.ack <= 1'b0;
      q.dat <= 32'h0000_0000;
      q.cfg.hdr_trl_en <= 1'b0;
      q.cfg.err_mark_en <= 1'b1;
      q.cfg.bypass_en <= 1'b0;
      q.cfg.dead_time <= tdcop_pkg::RST_DEAD;
      q.cfg.hit_limit <= tdcop_pkg::RST_LIM;
      q.cfg.err_type_en <= tdcop_pkg::RST_ERRT;
      q.cfg.buf_size <= tdcop_pkg::RST_BUF;
      q.chan_en <= '1;
      q.edge_mode <= tdcop_pkg::RST_EDGE;
      q.low_res <= 1'b0;
      q.lt_res <= tdcop_pkg::RST_LT_RES;
      q.pair_lead <= tdcop_pkg::RST_PAIR_LEAD;
      q.pair_width <= tdcop_pkg::RST_PAIR_WIDTH;
      q.hit_cnt <= 9'h000;
      q.over <= 1'b0;
      q.ev <= tdcop_pkg::EV_IDLE;
      q.keep <= 1'b0;
      q.serr <= 1'b0;
      q.trl <= 1'b0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign cfg_o = q.cfg;
  assign chan_en_o = q.chan_en;
  assign edge_mode_o = q.edge_mode;
  assign low_res_o = q.low_res;
  assign hit_keep_o = q.keep;
  assign size_err_o = q.serr;
  assign size_err_word_o = tdcop_pkg::SIZE_ERR_WORD;
  assign trailer_o = q.trl;

endmodule

// ===== test/tdcop_interp_asserts.sv
// Concurrent checks on the interpreter's ports.
`timescale 1ns/1ps
module tdcop_interp_asserts #(
  parameter int NCH = 32
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bus answer side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Settings and event guard
  input wire tdcop_pkg::tdcop_cfg_s cfg_o,
  input wire logic [NCH-1:0] chan_en_o,
  input wire logic hit_i,
  input wire logic evt_end_i,
  input wire logic hit_keep_o,
  input wire logic size_err_o,
  input wire logic [15:0] size_err_word_o,
  input wire logic trailer_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  keep_zero_a: assert property (ce_i && hit_i && cfg_o.hit_limit == 4'h0 |=> !hit_keep_o)
    else $error("hit kept with zero limit");
  keep_free_a: assert property (ce_i && hit_i && cfg_o.hit_limit >= 4'h9 |=> hit_keep_o)
    else $error("hit dropped without limit");
  err_word_a: assert property (size_err_o |-> size_err_word_o == tdcop_pkg::SIZE_ERR_WORD)
    else $error("wrong size error word");
  err_cause_a: assert property ($rose(size_err_o) |-> $past(evt_end_i, 2))
    else $error("size error not at event end");
  err_trl_a: assert property (size_err_o && cfg_o.hdr_trl_en && ce_i |=> trailer_o)
    else $error("trailer not after error word");
  trl_en_a: assert property (trailer_o |-> cfg_o.hdr_trl_en)
    else $error("trailer while disabled");
  chan_cmd_a: assert property ($changed(chan_en_o) |-> wb_ack_o)
    else $error("channel enables changed without command");
endmodule

bind tdcop_interp tdcop_interp_asserts #(.NCH(NCH)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_o(cfg_o),
  .chan_en_o(chan_en_o), .hit_i(hit_i), .evt_end_i(evt_end_i), .hit_keep_o(hit_keep_o),
  .size_err_o(size_err_o), .size_err_word_o(size_err_word_o), .trailer_o(trailer_o));

// ===== test/tdcop_host.sv
// Wishbone host model issuing opcodes, data words and response reads.
`timescale 1ns/1ps
module tdcop_host (
  // Clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  // Request
  output logic cyc_o = 1'b0,
  output logic stb_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [7:0] adr_o = 8'h00,
  output logic [3:0] sel_o = 4'h0,
  output logic [31:0] dat_o = 32'h0
);
  logic hung = 1'b0;
  // One classic cycle; the request stands until ack is sampled high or 20 cycles pass.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    hung = (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data lines flip so stale values are never mistaken for data.
    dat_o <= ~d;
  endtask
endmodule

// ===== test/tdcop_interp_tb.sv
// Self-checking bench for the opcode interpreter.
`timescale 1ns/1ps
module tdcop_interp_tb;
  // ------------------------------------------------
  // Signals and tables
  // ------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic hit_i = 1'b0;
  logic evt_end_i = 1'b0;
  logic cyc, stb, we, ack, keep, serr, trl, low_res;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, chan;
  logic [1:0] edge_m;
  logic [15:0] d;
  logic [4:0] ch;
  tdcop_pkg::tdcop_cfg_s cfg;
  logic [31:0] expq[$];
  int failures = 0;
  int samples_checked = 0;
  int nk, ne, nt;
  logic [7:0] rop[6] = '{8'h26, 8'h29, 8'h32, 8'h34, 8'h3a, 8'h3c};
  logic [15:0] rdef[6] = '{16'h3, 16'h0, 16'h0, 16'h9, 16'h7ff, 16'h7};
  logic [7:0] sop[4] = '{8'h28, 8'h33, 8'h39, 8'h3b};
  logic [15:0] msk[4] = '{16'h3, 16'hf, 16'h7ff, 16'h7};
  logic [7:0] onop[3] = '{8'h30, 8'h35, 8'h37};
  logic [3:0] lim[3] = '{4'h1, 4'h9, 4'h0};
  int nh[3] = '{3, 4, 2};
  int ek[3] = '{1, 4, 0};
  initial forever #2.5 clk_i = ~clk_i;
  tdcop_host host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat));
  tdcop_interp #(.NCH(32)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cfg_o(cfg), .chan_en_o(chan), .edge_mode_o(edge_m), .low_res_o(low_res), .hit_i(hit_i),
    .evt_end_i(evt_end_i), .hit_keep_o(keep), .size_err_o(serr), .size_err_word_o(), .trailer_o(trl));
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic chk_out(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t port exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t read exp %h got %h", $time, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] v);
    host.acc(w, a, {16'h0, v});
    if (host.hung) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expq.push_back({16'h0, e});
    bus(1'b0, a, 16'h0);
  endtask
  task automatic ask(input logic [7:0] op, input logic [15:0] e);
    wr(8'h00, {op, 8'h00});
    rd(8'h00, e);
  endtask
  // Counters are cleared off the edge so the monitor never races the clear.
  task automatic ev(input int n);
    @(negedge clk_i);
    nk = 0;
    ne = 0;
    nt = 0;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      hit_i <= 1'b1;
    end
    @(posedge clk_i);
    hit_i <= 1'b0;
    evt_end_i <= 1'b1;
    @(posedge clk_i);
    evt_end_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      chk_rd(expq.size() > 0 ? expq.pop_front() : 32'hx, rdat);
    end
    nk += int'(keep === 1'b1);
    ne += int'(serr === 1'b1);
    nt += int'(trl === 1'b1);
  end
  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(32'h3832));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_out({1'b0, 1'b1, 1'b0, 2'h0, 4'h9, 11'h7ff, 3'h7}, 32'(cfg));
    chk_out(32'hffffffff, chan);
    for (int i = 0; i < 6; i++) ask(rop[i], rdef[i]);
    $display("defaults done");
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom()) & msk[i];
      wr(8'h00, {sop[i], 8'h00});
      rd(8'h04, 16'h1);
      wr(8'h00, d);
      ask(sop[i] + 8'h01, d);
    end
    $display("settings done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, {onop[i], 8'h00});
      chk_out(1, cfg[22-i]);
      wr(8'h00, {onop[i] + 8'h01, 8'h00});
      chk_out(0, cfg[22-i]);
    end
    rd(8'h04, 16'h0);
    ask(8'h32, 16'h0);
    $display("switches done");
    hit_i <= 1'b1;
    wr(8'h00, 16'h4300);
    chk_out(0, chan);
    ch = 5'($urandom());
    wr(8'h00, {8'h40, 3'h0, ch});
    chk_out(32'h1 << ch, chan);
    wr(8'h00, 16'h4020);
    chk_out(32'h1 << ch, chan);
    wr(8'h00, 16'h4200);
    wr(8'h00, {8'h41, 3'h0, ch});
    chk_out(~(32'h1 << ch), chan);
    ev(0);
    $display("channels done");
    wr(8'h08, 16'hd514);
    rd(8'h04, 16'h4);
    chk_out(3'h4, {low_res, edge_m});
    ask(8'h26, 16'h0d05);
    wr(8'h08, 16'hd510);
    ask(8'h26, 16'h0001);
    rd(8'h00, 16'h0);
    rd(8'h0c, 16'h0);
    $display("resolution done");
    wr(8'h00, 16'h3000);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 16'h3300);
      wr(8'h00, {12'h0, lim[i]});
      ev(nh[i]);
      chk_out(ek[i], nk);
      chk_out(ek[i] != nh[i], ne);
      chk_out(1, nt);
    end
    // With the enable low a whole event must leave no trace.
    ce_i <= 1'b0;
    ev(3);
    chk_out(0, nk + ne + nt);
    ce_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_out(32'hffffffff, chan);
    ask(8'h32, 16'h0);
    $display("events done");
    end_sim();
  end
endmodule
